//--- pkg/lcd_bz_pkg.sv
// Purpose: shared constants and types for the display memory and tone block
// Assumes: 7-bit data memory addresses, 8-bit data
// Notes: build-time choices live as module parameters of the top
package lcd_bz_pkg;

    // ========================================
    // data memory map
    localparam logic [6:0] BANK_SEL_ADDR = 7'h04;
    localparam logic [6:0] RTC_CTRL_ADDR = 7'h09;
    localparam logic [6:0] PORT_A_ADDR = 7'h12;
    localparam logic [6:0] DISP_LO_ADDR = 7'h40;
    localparam logic [6:0] DISP_HI_ADDR = 7'h52;
    localparam int DISP_WORDS = 19;
    localparam int DISP_IDX_W = 5;

    // ========================================
    // register fields and reset values
    localparam logic [7:0] BANK_SEL_RST = 8'h00;
    localparam logic [7:0] RTC_CTRL_RST = 8'h07;
    localparam logic [7:0] RTC_CTRL_WMASK = 8'h17;
    localparam logic [7:0] PORT_A_RST = 8'hFF;
    localparam int BANK_FLAG_BIT = 0;
    localparam int TAP_SEL_LSB = 0;
    localparam int TAP_SEL_W = 3;
    localparam int FAST_DIS_BIT = 4;
    localparam int PA_BIT0 = 0;
    localparam int PA_BIT1 = 1;

    // ========================================
    // clock division
    localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
    localparam int DIV_W = 16;
    localparam int RTC_TAP_BASE = 8;
    localparam int SYNC_STAGES = 3;
    localparam int OSC_INPUTS = 2;
    localparam int OSC_RTC = 0;
    localparam int OSC_WDT = 1;

    // ========================================
    // panel geometry
    localparam int SEG_LINES = 19;
    localparam int MAX_COMS = 4;
    localparam int LAST_SEG = 18;

    typedef enum logic [1:0] {
        SRC_SYS_DIV4 = 2'b00,
        SRC_RTC_OSC = 2'b01,
        SRC_WDT_OSC = 2'b10
    } clk_src_t;

    typedef enum logic [1:0] {
        PH_COM0 = 2'b00,
        PH_COM1 = 2'b01,
        PH_COM2 = 2'b10,
        PH_COM3 = 2'b11
    } scan_phase_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic indirect;
        logic [6:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic [MAX_COMS-1:0] com;
        logic [SEG_LINES-1:0] seg;
        logic inv;
    } lcd_drive_t;

endpackage

//--- rtl/lcd_scan.sv
// Purpose: scans display memory out as common and segment drive levels
// Assumes: one scan step per lcd_tick_i pulse
// Notes: frame polarity flips after each full pass over the commons
`timescale 1ns/1ps
`default_nettype none
module lcd_scan #(
    parameter int NUM_COMS = 3
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic lcd_tick_i,
    input wire logic [lcd_bz_pkg::DISP_WORDS-1:0][7:0] disp_i,
    output lcd_bz_pkg::lcd_drive_t drive_o
);
    lcd_bz_pkg::scan_phase_t phase_r;
    lcd_bz_pkg::scan_phase_t phase_nxt;
    logic inv_r;
    logic last_ph;
    lcd_bz_pkg::lcd_drive_t drive_nxt;

    assign last_ph = (phase_r == lcd_bz_pkg::scan_phase_t'(NUM_COMS - 1));

    // ========================================
    // phase sequencing
    always_comb begin
        case (phase_r)
            lcd_bz_pkg::PH_COM0: phase_nxt = lcd_bz_pkg::PH_COM1;
            lcd_bz_pkg::PH_COM1: phase_nxt = lcd_bz_pkg::PH_COM2;
            lcd_bz_pkg::PH_COM2: phase_nxt = lcd_bz_pkg::PH_COM3;
            default: phase_nxt = lcd_bz_pkg::PH_COM0;
        endcase
        if (last_ph) begin
            phase_nxt = lcd_bz_pkg::PH_COM0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_r <= lcd_bz_pkg::PH_COM0;
            inv_r <= 1'b0;
        end else if (lcd_tick_i) begin
            phase_r <= phase_nxt;
            if (last_ph) begin
                inv_r <= ~inv_r;
            end
        end
    end

    // ========================================
    // drive levels
    genvar c;
    genvar s;
    generate
        for (c = 0; c < lcd_bz_pkg::MAX_COMS; c++) begin : g_com
            assign drive_nxt.com[c] = ((c < NUM_COMS) && (phase_r == c)) ^ inv_r;
        end
        for (s = 0; s < lcd_bz_pkg::SEG_LINES; s++) begin : g_seg
            if (s == lcd_bz_pkg::LAST_SEG) begin : g_last
                assign drive_nxt.seg[s] = (NUM_COMS == lcd_bz_pkg::MAX_COMS) ?
                    drive_nxt.com[lcd_bz_pkg::MAX_COMS-1] : disp_i[s][phase_r] ^ inv_r;
            end else begin : g_norm
                assign drive_nxt.seg[s] = disp_i[s][phase_r] ^ inv_r;
            end
        end
    endgenerate
    assign drive_nxt.inv = inv_r;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            drive_o <= '0;
        end else begin
            drive_o <= drive_nxt;
        end
    end

endmodule
`default_nettype wire

//--- rtl/lcd_memory_and_buzzer_ctrl.sv
// Purpose: display memory overlay, tone output, rtc control and clock dividers
// Assumes: core presents one data memory access per cycle on mem_req_i
// Notes: all build options are parameters fixed before reset release
//
// Behaviour
// - display memory occupies bank one addresses 40H to 52H over general RAM
// - bank flag at address 04H steers overlaid accesses
// - bank flag one: indirect writes in range land in display memory
// - bank flag zero: writes in range go to general RAM
// - display memory reached only by indirect access through pointer one
// - driver fetches display memory continuously on its own
// - stored one lights an element, zero blanks it
// - two, three or four commons chosen at build time
// - with four commons the last segment line becomes a common
// - lcd clock is source divided by 2^2 to 2^8
// - optional tone and its complement on port A bits zero and one
// - clearing port A bits zero and one together starts the tone
// - writing one to port A bit zero stops the tone
// - tone is source divided by 2^2 to 2^9
// - three-bit field picks one of eight rtc prescaler taps
// - fast rtc start-up bit: zero enables, one disables, resets zero
// - rtc control bits seven to five and bit three read zero
// - source clock is system clock/4, rtc or watchdog oscillator
`timescale 1ns/1ps
`default_nettype none
module lcd_memory_and_buzzer_ctrl #(
    parameter int NUM_COMS = 3,
    parameter bit TONE_EN = 1'b1,
    parameter int TONE_DIV_EXP = 4,
    parameter int LCD_DIV_EXP = 4,
    parameter lcd_bz_pkg::clk_src_t CLK_SRC = lcd_bz_pkg::SRC_SYS_DIV4
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire lcd_bz_pkg::mem_req_t mem_req_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic claim_o,
    output logic gp_ram_sel_o,
    input wire logic rtc_osc_i,
    input wire logic wdt_osc_i,
    output logic rtc_tap_o,
    output logic rtc_fast_dis_o,
    output lcd_bz_pkg::lcd_drive_t lcd_drive_o,
    output logic port_a_bit_zero_o,
    output logic port_a_bit_one_o,
    output logic tone_active_o
);
    // ========================================
    // access decode
    logic in_range;
    logic disp_hit;
    logic bank_hit;
    logic rtc_hit;
    logic pa_hit;
    logic bank_flag;
    logic [lcd_bz_pkg::DISP_IDX_W-1:0] disp_idx;
    logic [7:0] bank_sel_r;
    logic [7:0] rtc_ctrl_r;
    logic [lcd_bz_pkg::DISP_WORDS-1:0][7:0] disp_mem_r;
    logic [7:0] rd_mux;
    logic [6:0] idx_full;

    assign bank_flag = bank_sel_r[lcd_bz_pkg::BANK_FLAG_BIT];
    assign in_range = (mem_req_i.addr >= lcd_bz_pkg::DISP_LO_ADDR) &&
                      (mem_req_i.addr <= lcd_bz_pkg::DISP_HI_ADDR);
    assign disp_hit = in_range && bank_flag && mem_req_i.indirect;
    assign bank_hit = (mem_req_i.addr == lcd_bz_pkg::BANK_SEL_ADDR);
    assign rtc_hit = (mem_req_i.addr == lcd_bz_pkg::RTC_CTRL_ADDR);
    assign pa_hit = (mem_req_i.addr == lcd_bz_pkg::PORT_A_ADDR);
    assign idx_full = mem_req_i.addr - lcd_bz_pkg::DISP_LO_ADDR;
    assign disp_idx = idx_full[lcd_bz_pkg::DISP_IDX_W-1:0];
    assign claim_o = disp_hit || bank_hit || rtc_hit;
    assign gp_ram_sel_o = in_range && !disp_hit;

    // ========================================
    // registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bank_sel_r <= lcd_bz_pkg::BANK_SEL_RST;
        end else if (mem_req_i.wr && bank_hit) begin
            bank_sel_r <= mem_req_i.wdata;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rtc_ctrl_r <= lcd_bz_pkg::RTC_CTRL_RST;
        end else if (mem_req_i.wr && rtc_hit) begin
            rtc_ctrl_r <= mem_req_i.wdata & lcd_bz_pkg::RTC_CTRL_WMASK;
        end
    end
    assign rtc_fast_dis_o = rtc_ctrl_r[lcd_bz_pkg::FAST_DIS_BIT];

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            disp_mem_r <= '0;
        end else if (mem_req_i.wr && disp_hit) begin
            disp_mem_r[disp_idx] <= mem_req_i.wdata;
        end
    end

    // ========================================
    // read path
    always_comb begin
        rd_mux = 8'h00;
        if (disp_hit) begin
            rd_mux = disp_mem_r[disp_idx];
        end else if (bank_hit) begin
            rd_mux = bank_sel_r;
        end else if (rtc_hit) begin
            rd_mux = rtc_ctrl_r;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_o <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= mem_req_i.rd && claim_o;
            if (mem_req_i.rd && claim_o) begin
                rd_data_o <= rd_mux;
            end
        end
    end

    // ========================================
    // oscillator synchronisers
    logic [lcd_bz_pkg::OSC_INPUTS-1:0] osc_pin;
    logic [lcd_bz_pkg::OSC_INPUTS-1:0] osc_s1_r;
    logic [lcd_bz_pkg::OSC_INPUTS-1:0] osc_s2_r;
    logic [lcd_bz_pkg::OSC_INPUTS-1:0] osc_s3_r;
    logic [lcd_bz_pkg::OSC_INPUTS-1:0] osc_filt_r;
    logic [lcd_bz_pkg::OSC_INPUTS-1:0] osc_rise;

    assign osc_pin = {wdt_osc_i, rtc_osc_i};
    genvar g;
    generate
        for (g = 0; g < lcd_bz_pkg::OSC_INPUTS; g++) begin : g_sync
            always_ff @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    osc_s1_r[g] <= 1'b0;
                    osc_s2_r[g] <= 1'b0;
                    osc_s3_r[g] <= 1'b0;
                    osc_filt_r[g] <= 1'b0;
                end else begin
                    osc_s1_r[g] <= osc_pin[g];
                    osc_s2_r[g] <= osc_s1_r[g];
                    osc_s3_r[g] <= osc_s2_r[g];
                    if (osc_s2_r[g] == osc_s3_r[g]) begin
                        osc_filt_r[g] <= osc_s3_r[g];
                    end
                end
            end
            assign osc_rise[g] = (osc_s2_r[g] == osc_s3_r[g]) && osc_s3_r[g] &&
                                 !osc_filt_r[g];
        end
    endgenerate

    // ========================================
    // source clock and divider chain
    logic [1:0] sys_div_r;
    logic src_tick;
    logic [lcd_bz_pkg::DIV_W-1:0] div_cnt_r;
    logic [lcd_bz_pkg::DIV_W-1:0] div_nxt;
    logic lcd_tick;
    logic [lcd_bz_pkg::TAP_SEL_W-1:0] tap_sel;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sys_div_r <= 2'h0;
        end else begin
            sys_div_r <= sys_div_r + 2'h1;
        end
    end

    always_comb begin
        case (CLK_SRC)
            lcd_bz_pkg::SRC_RTC_OSC: src_tick = osc_rise[lcd_bz_pkg::OSC_RTC];
            lcd_bz_pkg::SRC_WDT_OSC: src_tick = osc_rise[lcd_bz_pkg::OSC_WDT];
            default: src_tick = (sys_div_r == lcd_bz_pkg::SYS_DIV4_LAST);
        endcase
    end

    assign div_nxt = div_cnt_r + 1'b1;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_cnt_r <= '0;
        end else if (src_tick) begin
            div_cnt_r <= div_nxt;
        end
    end

    assign lcd_tick = src_tick && div_nxt[LCD_DIV_EXP-1] && !div_cnt_r[LCD_DIV_EXP-1];

    assign tap_sel = rtc_ctrl_r[lcd_bz_pkg::TAP_SEL_LSB +: lcd_bz_pkg::TAP_SEL_W];
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rtc_tap_o <= 1'b0;
        end else begin
            rtc_tap_o <= div_cnt_r[lcd_bz_pkg::RTC_TAP_BASE + int'(tap_sel)];
        end
    end

    // ========================================
    // tone control on port A bits zero and one
    logic tone_on_r;
    logic pa0_lat_r;
    logic pa1_lat_r;
    logic tone;

    assign tone = div_cnt_r[TONE_DIV_EXP-1];
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pa0_lat_r <= lcd_bz_pkg::PORT_A_RST[lcd_bz_pkg::PA_BIT0];
            pa1_lat_r <= lcd_bz_pkg::PORT_A_RST[lcd_bz_pkg::PA_BIT1];
        end else if (mem_req_i.wr && pa_hit) begin
            pa0_lat_r <= mem_req_i.wdata[lcd_bz_pkg::PA_BIT0];
            pa1_lat_r <= mem_req_i.wdata[lcd_bz_pkg::PA_BIT1];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tone_on_r <= 1'b0;
        end else if (TONE_EN && mem_req_i.wr && pa_hit) begin
            if (mem_req_i.wdata[lcd_bz_pkg::PA_BIT0]) begin
                tone_on_r <= 1'b0;
            end else if (!mem_req_i.wdata[lcd_bz_pkg::PA_BIT1]) begin
                tone_on_r <= 1'b1;
            end
        end
    end
    assign tone_active_o = tone_on_r;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            port_a_bit_zero_o <= lcd_bz_pkg::PORT_A_RST[lcd_bz_pkg::PA_BIT0];
            port_a_bit_one_o <= lcd_bz_pkg::PORT_A_RST[lcd_bz_pkg::PA_BIT1];
        end else if (tone_on_r) begin
            port_a_bit_zero_o <= tone;
            port_a_bit_one_o <= ~tone;
        end else begin
            port_a_bit_zero_o <= pa0_lat_r;
            port_a_bit_one_o <= pa1_lat_r;
        end
    end

    // ========================================
    // panel scan
    lcd_scan #(
        .NUM_COMS(NUM_COMS)
    ) u_scan (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .lcd_tick_i(lcd_tick),
        .disp_i(disp_mem_r),
        .drive_o(lcd_drive_o)
    );

    // ========================================
    // checks
    logic [lcd_bz_pkg::DISP_IDX_W-1:0] chk_idx_r;
    logic [7:0] chk_data_r;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            chk_idx_r <= '0;
            chk_data_r <= 8'h00;
        end else begin
            chk_idx_r <= disp_idx;
            chk_data_r <= mem_req_i.wdata;
        end
    end

    sequence s_disp_write;
        mem_req_i.wr && disp_hit;
    endsequence

    sequence s_rtc_read;
        mem_req_i.rd && rtc_hit;
    endsequence

    sequence s_pa_write_stop;
        mem_req_i.wr && pa_hit && mem_req_i.wdata[lcd_bz_pkg::PA_BIT0];
    endsequence

    sequence s_pa_write_start;
        mem_req_i.wr && pa_hit && (mem_req_i.wdata[1:0] == 2'b00);
    endsequence

    a_bank_flag_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (mem_req_i.wr && bank_hit) |=> (bank_flag == $past(mem_req_i.wdata[0])))
        else $error("bank flag not updated");

    a_disp_write_lands: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        s_disp_write |=> (disp_mem_r[chk_idx_r] == chk_data_r))
        else $error("display write lost");

    a_bank0_to_ram: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (in_range && !bank_flag) |-> (gp_ram_sel_o && !claim_o))
        else $error("bank zero access claimed by display");

    a_direct_blocked: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (in_range && !mem_req_i.indirect) |-> (!claim_o ##1 $stable(disp_mem_r)))
        else $error("direct access reached display memory");

    a_rtc_read_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        s_rtc_read |=> (rd_valid_o && (rd_data_o[7:5] == 3'b000) && !rd_data_o[3]))
        else $error("rtc control upper bits not zero");

    a_tap_select: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        ##1 (rtc_tap_o == $past(div_cnt_r[lcd_bz_pkg::RTC_TAP_BASE + int'(tap_sel)])))
        else $error("rtc tap mismatch");

    a_tone_stop: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        s_pa_write_stop |=> !tone_on_r ##1 (port_a_bit_zero_o == $past(pa0_lat_r)))
        else $error("tone not stopped");

    a_tone_start: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        s_pa_write_start |=> (tone_on_r == TONE_EN))
        else $error("tone not started");

    a_tone_pair: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        tone_on_r |=> (port_a_bit_one_o != port_a_bit_zero_o))
        else $error("tone pins not complementary");

    a_lcd_tick_div: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        lcd_tick |=> (div_cnt_r[LCD_DIV_EXP-2:0] == '0) && div_cnt_r[LCD_DIV_EXP-1])
        else $error("lcd clock division wrong");

    a_fast_reset: assert property (@(posedge clk_sys_i)
        !rstn_i |=> (!rtc_fast_dis_o || !rstn_i))
        else $error("fast start-up bit not zero after reset");

    a_src_tick_rate: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (CLK_SRC == lcd_bz_pkg::SRC_SYS_DIV4) && src_tick |=> !src_tick [*3] ##1 src_tick)
        else $error("source tick not every fourth clock");

    a_direct_read_none: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (mem_req_i.rd && in_range && !mem_req_i.indirect) |=> !rd_valid_o)
        else $error("direct read answered from display memory");

endmodule
`default_nettype wire

//--- tb/lcd_panel_model.sv
// Purpose: glass panel and tone transducer seen from the drive pins
// Assumes: common selected while its level differs from the frame polarity
// Notes: latches the spacing of common steps and tone half periods
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire lcd_bz_pkg::lcd_drive_t drive_i,
    input wire logic tone_i,
    output logic [18:0][3:0] lit_o,
    output int com_gap_o,
    output int tone_half_o,
    output int tone_edges_o
);
    // ========================================
    // element states and timing
    int com_cnt;
    int tone_cnt;
    logic [3:0] com_q;
    logic tone_q;

    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lit_o <= '0;
            com_gap_o <= 0;
            tone_half_o <= 0;
            tone_edges_o <= 0;
            com_cnt <= 0;
            tone_cnt <= 0;
            com_q <= '0;
            tone_q <= 1'b1;
        end else begin
            com_q <= drive_i.com;
            tone_q <= tone_i;
            com_cnt <= (drive_i.com != com_q) ? 1 : com_cnt + 1;
            if (drive_i.com != com_q) begin
                com_gap_o <= com_cnt;
            end
            tone_cnt <= (tone_i != tone_q) ? 1 : tone_cnt + 1;
            if (tone_i != tone_q) begin
                tone_half_o <= tone_cnt;
            end
            if (tone_i && !tone_q) begin
                tone_edges_o <= tone_edges_o + 1;
            end
            for (int c = 0; c < 4; c++) begin
                if (drive_i.com[c] != drive_i.inv) begin
                    for (int s = 0; s < 19; s++) begin
                        lit_o[s][c] <= drive_i.seg[s] ^ drive_i.inv;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/lcd_memory_and_buzzer_ctrl_bench.sv
// Purpose: self-checking bench for display memory, tone and rtc control
// Assumes: system clock/4 source, four commons, tone enabled
// Notes: model keeps display bytes and register values as integers
`timescale 1ns/1ps
`default_nettype none
module lcd_memory_and_buzzer_ctrl_bench;
    localparam int LCD_EXP = 4;
    localparam int TONE_EXP = 4;
    localparam logic [6:0] LO = lcd_bz_pkg::DISP_LO_ADDR;
    localparam logic [6:0] RTC = lcd_bz_pkg::RTC_CTRL_ADDR;
    localparam logic [6:0] BANK = lcd_bz_pkg::BANK_SEL_ADDR;
    localparam logic [6:0] PA = lcd_bz_pkg::PORT_A_ADDR;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic rtc_osc_i = 1'b0;
    logic wdt_osc_i = 1'b0;
    lcd_bz_pkg::mem_req_t req = '0;
    logic [7:0] rd_data_o;
    logic rd_valid_o, claim_o, gp_ram_sel_o, rtc_tap_o, rtc_fast_dis_o, tone_active_o;
    logic pa0, pa1;
    lcd_bz_pkg::lcd_drive_t lcd_drive_o;
    logic [18:0][3:0] lit;
    int com_gap, tone_half, tone_edges, v, e0, cyc;
    int failures = 0;
    int tests_run = 0;
    int disp[19];
    int unsigned seed = 58555;

    // ========================================
    // clock, stimulus helpers
    always #12.5 clk_sys_i = ~clk_sys_i;

    // clock edges since reset release, for the prescaler model
    always @(posedge clk_sys_i) begin
        if (rstn_i) begin
            cyc <= cyc + 1;
        end
    end

    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    always @(posedge clk_sys_i) begin
        #1;
        rtc_osc_i <= 1'(rnd() >> 3);
        wdt_osc_i <= 1'(rnd() >> 5);
    end

    lcd_memory_and_buzzer_ctrl #(.NUM_COMS(4), .TONE_EN(1'b1), .TONE_DIV_EXP(TONE_EXP),
        .LCD_DIV_EXP(LCD_EXP), .CLK_SRC(lcd_bz_pkg::SRC_SYS_DIV4)) lcd_memory_and_buzzer_ctrl_i (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .mem_req_i(req), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .claim_o(claim_o), .gp_ram_sel_o(gp_ram_sel_o),
        .rtc_osc_i(rtc_osc_i), .wdt_osc_i(wdt_osc_i), .rtc_tap_o(rtc_tap_o),
        .rtc_fast_dis_o(rtc_fast_dis_o), .lcd_drive_o(lcd_drive_o), .port_a_bit_zero_o(pa0),
        .port_a_bit_one_o(pa1), .tone_active_o(tone_active_o));

    lcd_panel_model lcd_panel_model_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .drive_i(lcd_drive_o), .tone_i(pa0), .lit_o(lit), .com_gap_o(com_gap),
        .tone_half_o(tone_half), .tone_edges_o(tone_edges));

    // ========================================
    // compare, access and closing tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t %s seen %0h expected %0h", $time, m, seen, exp);
        end
    endtask

    task acc(input bit w, input bit r, input bit ind, input logic [6:0] a, input int d,
             input bit ecl, input bit egp, input int erd);
        @(posedge clk_sys_i);
        #1;
        req = '{wr: w, rd: r, indirect: ind, addr: a, wdata: d[7:0]};
        #5;
        chk(claim_o, ecl, "claim");
        chk(gp_ram_sel_o, egp, "general ram select");
        @(posedge clk_sys_i);
        #1;
        req = '0;
        if (r) begin
            chk(rd_valid_o, ecl, "read valid");
            if (ecl) begin
                chk(rd_data_o, erd, "read data");
            end
        end
    endtask

    task panel_chk();
        for (int i = 0; i < 600; i++) begin
            @(posedge clk_sys_i);
            #2;
            chk(lcd_drive_o.seg[18], lcd_drive_o.com[3], "fourth common line");
        end
        for (int s = 0; s < 18; s++) begin
            for (int c = 0; c < 4; c++) begin
                chk(lit[s][c], (disp[s] >> c) & 1, "element");
            end
        end
        chk(com_gap, 4 << LCD_EXP, "lcd step spacing");
    endtask

    task stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        stop_test();
    end

    // ========================================
    // scenarios
    initial begin
        repeat (20) @(posedge clk_sys_i);
        #1;
        rstn_i = 1'b1;
        acc(0, 1, 0, RTC, 0, 1, 0, 8'h07);
        acc(0, 1, 0, BANK, 0, 1, 0, 8'h00);
        chk(rtc_fast_dis_o, 0, "fast start reset");
        chk(tone_active_o, 0, "tone reset");
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'hFF : int'(rnd() & 8'hFF);
            acc(1, 0, 0, RTC, v, 1, 0, 0);
            acc(0, 1, 0, RTC, 0, 1, 0, v & 8'h17);
            chk(rtc_fast_dis_o, (v >> 4) & 1, "fast start bit");
        end
        $display("rtc control test done");
        acc(1, 0, 0, BANK, 8'h01, 1, 0, 0);
        acc(0, 1, 0, BANK, 0, 1, 0, 8'h01);
        for (int k = 0; k < 19; k++) begin
            disp[k] = int'(rnd() & 8'hFF);
            acc(1, 0, 1, LO + 7'(k), disp[k], 1, 0, 0);
        end
        for (int k = 0; k < 19; k++) begin
            acc(0, 1, 1, LO + 7'(k), 0, 1, 0, disp[k]);
        end
        acc(1, 0, 0, LO + 7'h05, 8'h3C, 0, 1, 0);
        acc(0, 1, 0, LO + 7'h05, 0, 0, 1, 0);
        acc(1, 0, 1, 7'h3F, 8'h11, 0, 0, 0);
        acc(1, 0, 1, 7'h53, 8'h11, 0, 0, 0);
        acc(1, 0, 0, BANK, 8'hFE, 1, 0, 0);
        acc(1, 0, 1, LO, 8'h5A, 0, 1, 0);
        acc(0, 1, 1, LO, 0, 0, 1, 0);
        acc(1, 0, 0, BANK, 8'h01, 1, 0, 0);
        acc(0, 1, 1, LO, 0, 1, 0, disp[0]);
        acc(0, 1, 1, LO + 7'h05, 0, 1, 0, disp[5]);
        $display("bank test done");
        panel_chk();
        disp[3] = ~disp[3] & 8'hFF;
        acc(1, 0, 1, LO + 7'h03, disp[3], 1, 0, 0);
        panel_chk();
        $display("panel test done");
        e0 = tone_edges;
        acc(1, 0, 0, PA, 8'hFC, 0, 0, 0);
        chk(tone_active_o, 1, "tone on");
        repeat (4) @(posedge clk_sys_i);
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_sys_i);
            #2;
            chk(pa1 ^ pa0, 1, "complement pin");
        end
        chk(tone_edges - e0 > 2, 1, "tone running");
        chk(tone_half, 4 << (TONE_EXP - 1), "tone half period");
        acc(1, 0, 0, PA, 8'h02, 0, 0, 0);
        chk(tone_active_o, 1, "tone kept");
        acc(1, 0, 0, PA, 8'h01, 0, 0, 0);
        chk(tone_active_o, 0, "tone off");
        repeat (2) @(posedge clk_sys_i);
        #2;
        chk({pa1, pa0}, 2'b01, "port latch pins");
        e0 = tone_edges;
        acc(1, 0, 0, PA, 8'h02, 0, 0, 0);
        repeat (100) @(posedge clk_sys_i);
        #2;
        chk(tone_edges, e0, "tone stays off");
        chk(tone_active_o, 0, "tone inactive");
        chk(rtc_tap_o, ((cyc - 1) / 4 >> (lcd_bz_pkg::RTC_TAP_BASE + (v & 7))) & 1, "rtc tap");
        $display("tone test done");
        stop_test();
    end
endmodule
`default_nettype wire
